// ===== logic/ptb_defs.svh
// constants for the pci target bar decode control block
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH
// ****************
// register map
// ****************
`define PTB_ADDR_W 12
`define PTB_CTRL_OFS 12'h05C
`define PTB_CTRL_RST 32'h0000_1100
`define PTB_CTRL_MASK 32'h000F_FFFF
// ****************
// field positions
// ****************
`define PTB_SPECIAL_WR_BIT 19
`define PTB_INCR_RETRY_DIS_BIT 18
`define PTB_IO_WIN_EN_BIT 17
`define PTB_MEM_WIN_EN_BIT 16
`define PTB_ENC_W 4
`define PTB_NUM_MBAR 4
// ****************
// window geometry
// ****************
`define PTB_OFS_LSB 14
`define PTB_OFS_W 18
`define PTB_LOG2_2GB 5'd31
`define PTB_LOG2_4MB 5'd22
`define PTB_LOG2_2MB 5'd21
`define PTB_LOG2_1MB 5'd20
`define PTB_LOG2_64K 5'd16
`define PTB_LOG2_32K 5'd15
`define PTB_LOG2_16K 5'd14
`endif

// ===== logic/ptb_pkg.sv
// types for the pci target bar decode control block
`include "ptb_defs.svh"
package ptb_pkg;
  typedef logic [`PTB_ENC_W-1:0] ptb_enc_t;
  typedef logic [4:0] ptb_log2_t;
  typedef logic [`PTB_OFS_W-1:0] ptb_ofs_t;
  typedef logic [`PTB_ADDR_W-1:0] ptb_addr_t;
  typedef enum logic [3:0] {
    PTB_ENC_OFF = 4'h0,
    PTB_ENC_2GB = 4'h1,
    PTB_ENC_8MB = 4'h9,
    PTB_ENC_4MB = 4'hA,
    PTB_ENC_2MB = 4'hB,
    PTB_ENC_1MB = 4'hC,
    PTB_ENC_64K = 4'hD,
    PTB_ENC_32K = 4'hE,
    PTB_ENC_16K = 4'hF
  } ptb_enc_code_t;
  typedef struct packed {
    logic en;
    logic win;
    ptb_log2_t log2;
  } ptb_bar_cfg_t;
endpackage

// ===== logic/ptb_dec_if.sv
// carrier between control register and size decoder
`timescale 1ns/1ns
interface ptb_dec_if;
  import ptb_pkg::*;
  ptb_enc_t enc [`PTB_NUM_MBAR];
  ptb_bar_cfg_t cfg [`PTB_NUM_MBAR];
  modport ctrl (output enc, input cfg);
  modport dec (input enc, output cfg);
endinterface

// ===== logic/ptb_size_dec.sv
// size encoding decoder for memory bars 3 to 6
`timescale 1ns/1ns
module ptb_size_dec (
  ptb_dec_if.dec dec
);
  import ptb_pkg::*;
  // ****************
  // encoding to window
  // ****************
  function automatic ptb_bar_cfg_t decode(input ptb_enc_t e);
    ptb_bar_cfg_t c;
    c = '0;
    c.en = (e != PTB_ENC_OFF);
    if (e >= PTB_ENC_2GB && e <= PTB_ENC_8MB) begin
      c.log2 = 5'(`PTB_LOG2_2GB + 5'd1 - {1'b0, e});
    end else if (e == PTB_ENC_4MB) begin
      c.log2 = `PTB_LOG2_4MB;
    end else if (e == PTB_ENC_2MB) begin
      c.log2 = `PTB_LOG2_2MB;
    end else if (e == PTB_ENC_1MB) begin
      c.log2 = `PTB_LOG2_1MB;
    end else if (e == PTB_ENC_64K) begin
      c.log2 = `PTB_LOG2_64K;
      c.win = 1'b1;
    end else if (e == PTB_ENC_32K) begin
      c.log2 = `PTB_LOG2_32K;
      c.win = 1'b1;
    end else if (e == PTB_ENC_16K) begin
      c.log2 = `PTB_LOG2_16K;
      c.win = 1'b1;
    end
    return c;
  endfunction

  for (genvar i = 0; i < `PTB_NUM_MBAR; i++) begin : g_bar
    assign dec.cfg[i] = decode(dec.enc[i]);
  end
endmodule

// ===== logic/ptb_bar_ctrl.sv
// base address decode control register and its decode outputs
`timescale 1ns/1ns
module ptb_bar_ctrl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire ptb_pkg::ptb_addr_t reg_addr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic cfg_ro_wr_i,
  output logic cfg_ro_wr_ok_o,
  input wire logic retry_req_i,
  input wire logic first_phase_i,
  output logic retry_o,
  input wire logic cmd_io_en_i,
  output logic io_dec_en_o,
  output logic bar1_zero_o,
  output logic mem_dec_en_o,
  output logic [3:0] mbar_en_o,
  output logic [3:0] mbar_win_o,
  output logic [19:0] mbar_log2_o,
  input wire logic [1:0] xlat_bar_i,
  input wire logic [31:0] xlat_addr_i,
  input wire ptb_pkg::ptb_ofs_t xlat_ofs_i,
  output logic [31:0] xlat_addr_o
);
  import ptb_pkg::*;

  // ****************
  // control register
  // ****************
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] be_mask;
  logic ctrl_hit;
  assign ctrl_hit = (reg_addr_i == `PTB_CTRL_OFS);
  assign be_mask = {{8{reg_be_i[3]}}, {8{reg_be_i[2]}}, {8{reg_be_i[1]}}, {8{reg_be_i[0]}}};
  assign ctrl_d = ((ctrl_q & ~be_mask) | (reg_wdata_i & be_mask)) & `PTB_CTRL_MASK;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `PTB_CTRL_RST;
    end else if (reg_wr_i && ctrl_hit) begin
      ctrl_q <= ctrl_d;
    end
  end

  logic [31:0] rdata_d;
  assign rdata_d = (reg_rd_i && ctrl_hit) ? ctrl_q : 32'h0000_0000;

  // ****************
  // decode controls
  // ****************
  logic special_wr;
  logic retry_dis;
  logic io_win;
  logic mem_win;
  assign special_wr = ctrl_q[`PTB_SPECIAL_WR_BIT];
  assign retry_dis = ctrl_q[`PTB_INCR_RETRY_DIS_BIT];
  assign io_win = ctrl_q[`PTB_IO_WIN_EN_BIT];
  assign mem_win = ctrl_q[`PTB_MEM_WIN_EN_BIT];

  logic ro_ok_d;
  logic retry_d;
  assign ro_ok_d = cfg_ro_wr_i & special_wr;
  assign retry_d = retry_req_i & ~(retry_dis & ~first_phase_i);

  ptb_dec_if dif ();
  for (genvar i = 0; i < `PTB_NUM_MBAR; i++) begin : g_enc
    assign dif.enc[i] = ctrl_q[i*`PTB_ENC_W +: `PTB_ENC_W];
  end
  ptb_size_dec u_dec (
    .dec(dif)
  );

  logic [3:0] en_d;
  logic [3:0] win_d;
  logic [19:0] log2_d;
  for (genvar i = 0; i < `PTB_NUM_MBAR; i++) begin : g_cfg
    assign en_d[i] = dif.cfg[i].en;
    assign win_d[i] = dif.cfg[i].win;
    assign log2_d[i*5 +: 5] = dif.cfg[i].log2;
  end

  // ****************
  // windowed address
  // ****************
  ptb_bar_cfg_t sel_cfg;
  logic [31:0] low_mask;
  logic [31:0] xlat_d;
  assign sel_cfg = dif.cfg[xlat_bar_i];
  assign low_mask = ~(32'hFFFF_FFFF << sel_cfg.log2);
  assign xlat_d = sel_cfg.win ? ((xlat_addr_i & low_mask) + {xlat_ofs_i, 14'h0000}) : xlat_addr_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
      cfg_ro_wr_ok_o <= 1'b0;
      retry_o <= 1'b0;
      io_dec_en_o <= 1'b0;
      bar1_zero_o <= 1'b1;
      mem_dec_en_o <= 1'b0;
      mbar_en_o <= 4'h0;
      mbar_win_o <= 4'h0;
      mbar_log2_o <= 20'h0_0000;
      xlat_addr_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= rdata_d;
      cfg_ro_wr_ok_o <= ro_ok_d;
      retry_o <= retry_d;
      io_dec_en_o <= io_win & cmd_io_en_i;
      bar1_zero_o <= ~io_win;
      mem_dec_en_o <= mem_win;
      mbar_en_o <= en_d;
      mbar_win_o <= win_d;
      mbar_log2_o <= log2_d;
      xlat_addr_o <= xlat_d;
    end
  end

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  special_wr_a: assert property (cfg_ro_wr_i && ctrl_q[19] |=> cfg_ro_wr_ok_o)
    else $error("unlocked read-only write not granted");

  special_off_a: assert property (!ctrl_q[19] |=> !cfg_ro_wr_ok_o)
    else $error("locked read-only write granted");

  retry_sup_a: assert property (retry_req_i && !first_phase_i && ctrl_q[18] |=> !retry_o)
    else $error("retry on later burst phase while disabled");

  retry_pass_a: assert property (retry_req_i && (first_phase_i || !ctrl_q[18]) |=> retry_o)
    else $error("allowed retry dropped");

  retry_idle_a: assert property (!retry_req_i |=> !retry_o)
    else $error("retry without request");

  io_dec_a: assert property (io_dec_en_o == ($past(ctrl_q[17]) && $past(cmd_io_en_i)))
    else $error("io decode enable mismatch");

  io_off_a: assert property (!cmd_io_en_i |=> !io_dec_en_o)
    else $error("io decode without command enable");

  bar1_zero_a: assert property (!ctrl_q[17] |=> bar1_zero_o)
    else $error("bar 1 not forced to zero");

  bar1_read_a: assert property (ctrl_q[17] |=> !bar1_zero_o)
    else $error("bar 1 forced to zero while enabled");

  mem_dec_a: assert property (reg_wr_i && ctrl_hit && reg_be_i[2] |=> ##1 mem_dec_en_o == $past(reg_wdata_i[16], 2))
    else $error("memory decode enable not following write");

  mem_dec_q_a: assert property (mem_dec_en_o == $past(ctrl_q[16]))
    else $error("memory decode enable not following register");

  enc_field_a: assert property (reg_wr_i && ctrl_hit && reg_be_i[1] |=> ##1 mbar_en_o[3] == ($past(reg_wdata_i[15:12], 2) != 4'h0))
    else $error("bar 6 field misplaced");

  // ****************
  // register reads, bar size decode and address windowing
  // ****************
  rdata_a: assert property (reg_rd_i && ctrl_hit |=> reg_rdata_o == $past(ctrl_q))
    else $error("control register read wrong");

  rdata_idle_a: assert property (!(reg_rd_i && ctrl_hit) |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero when idle");

  rsvd_bits_a: assert property (ctrl_q[31:20] == 12'h000)
    else $error("unimplemented control bits set");

  bar_off_a: assert property (ctrl_q[3:0] == 4'h0 |=> !mbar_en_o[0] && !mbar_win_o[0])
    else $error("disabled bar still enabled");

  off_log2_a: assert property (ctrl_q[3:0] == 4'h0 |=> mbar_log2_o[4:0] == 5'd0)
    else $error("disabled bar has a size");

  bar4_off_a: assert property (ctrl_q[7:4] == 4'h0 |=> !mbar_en_o[1])
    else $error("bar 4 enabled while off");

  bar5_en_a: assert property (ctrl_q[11:8] != 4'h0 |=> mbar_en_o[2])
    else $error("bar 5 not enabled");

  size_a: assert property (ctrl_q[3:0] >= 4'h1 && ctrl_q[3:0] <= 4'h9 |=> mbar_log2_o[4:0] == 5'(6'd32 - $past({2'b00, ctrl_q[3:0]})) && !mbar_win_o[0])
    else $error("bar 3 size wrong");

  win_small_a: assert property (ctrl_q[3:0] >= 4'hE |=> mbar_win_o[0] && mbar_log2_o[4:0] == ($past(ctrl_q[0]) ? 5'd14 : 5'd15))
    else $error("small window decode wrong");

  win_large_a: assert property (ctrl_q[3:0] != 4'h0 && ctrl_q[3:0] < 4'hD |=> !mbar_win_o[0])
    else $error("windowing on for large window");

  bar6_size_a: assert property (ctrl_q[15:12] == 4'hF |=> mbar_log2_o[19:15] == 5'd14 && mbar_win_o[3])
    else $error("bar 6 small window wrong");

  enc_ad_a: assert property (ctrl_q[3:0] == 4'hD |=> mbar_win_o[0] && mbar_log2_o[4:0] == 5'd16)
    else $error("64K windowed decode wrong");

  enc_a4_a: assert property (ctrl_q[3:0] == 4'hA |=> mbar_log2_o[4:0] == 5'd22 && !mbar_win_o[0])
    else $error("4 MB decode wrong");

  xlat_a: assert property (xlat_bar_i == 2'd0 && ctrl_q[3:0] == 4'hF |=> xlat_addr_o == ({$past(xlat_ofs_i), 14'h0000} + ($past(xlat_addr_i) & 32'h0000_3FFF)))
    else $error("windowed address wrong");

  xlat_thru_a: assert property (xlat_bar_i == 2'd0 && ctrl_q[3:0] < 4'hD |=> xlat_addr_o == $past(xlat_addr_i))
    else $error("unwindowed address altered");
endmodule

// ===== tb/ptb_host_model.sv
// host master model for the control register port
`timescale 1ns/1ns
module ptb_host_model (
  input wire logic clk_i,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output ptb_pkg::ptb_addr_t reg_addr_o = '0,
  output logic [3:0] reg_be_o = 4'h0,
  output logic [31:0] reg_wdata_o = 32'h0
);
  import ptb_pkg::*;
  // hold through the sampling edge, then scramble released lines
  task acc(bit w, ptb_addr_t a, logic [3:0] be, logic [31:0] d);
    @(posedge clk_i);
    reg_wr_o <= w;
    reg_rd_o <= !w;
    reg_addr_o <= a;
    reg_be_o <= be;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_be_o <= ~be;
    reg_wdata_o <= ~d;
  endtask
endmodule

// ===== tb/pci_target_bar_decode_control_tb.sv
// self-checking bench for the bar decode control block
`timescale 1ns/1ns
module pci_target_bar_decode_control_tb;
  import ptb_pkg::*;
  typedef struct {int d; int k; logic [31:0] v;} ptb_note_t;
  ptb_note_t q[$];
  ptb_note_t n;
  logic clk_i = 0, reset_n_i = 0, cfg_ro_wr_i = 0, retry_req_i = 0, first_phase_i = 0, cmd_io_en_i = 0;
  logic [1:0] xlat_bar_i = 0;
  logic [31:0] xlat_addr_i = 0, c, r, a;
  ptb_ofs_t xlat_ofs_i = 0;
  wire logic reg_wr_i, reg_rd_i, cfg_ro_wr_ok_o, retry_o, io_dec_en_o, bar1_zero_o, mem_dec_en_o;
  wire logic [3:0] reg_be_i, mbar_en_o, mbar_win_o;
  wire logic [19:0] mbar_log2_o;
  wire logic [31:0] reg_wdata_i, reg_rdata_o, xlat_addr_o;
  wire ptb_addr_t reg_addr_i;
  int cyc = 0, error_cnt = 0, check_count = 0;
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  ptb_host_model ptb_host_model_i (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_be_o(reg_be_i), .reg_wdata_o(reg_wdata_i));
  ptb_bar_ctrl ptb_bar_ctrl_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cfg_ro_wr_i(cfg_ro_wr_i), .cfg_ro_wr_ok_o(cfg_ro_wr_ok_o), .retry_req_i(retry_req_i),
    .first_phase_i(first_phase_i), .retry_o(retry_o), .cmd_io_en_i(cmd_io_en_i), .io_dec_en_o(io_dec_en_o),
    .bar1_zero_o(bar1_zero_o), .mem_dec_en_o(mem_dec_en_o), .mbar_en_o(mbar_en_o), .mbar_win_o(mbar_win_o),
    .mbar_log2_o(mbar_log2_o), .xlat_bar_i(xlat_bar_i), .xlat_addr_i(xlat_addr_i), .xlat_ofs_i(xlat_ofs_i),
    .xlat_addr_o(xlat_addr_o));
  function automatic logic [4:0] l2(logic [3:0] e);
    return e == 0 ? 5'h0 : e < 4'hD ? 5'(32 - e) : 5'(29 - e);
  endfunction
  function automatic logic [31:0] dec(logic [31:0] c);
    logic [31:0] v;
    v = {2'h0, c[16], ~c[17], 28'h0};
    for (int i = 0; i < 4; i++) begin
      v[24+i] = |c[4*i+:4];
      v[20+i] = c[4*i+:4] >= 4'hD;
      v[5*i+:5] = l2(c[4*i+:4]);
    end
    return v;
  endfunction
  function automatic logic [31:0] xl(logic [3:0] e, logic [31:0] a, ptb_ofs_t o);
    return e >= 4'hD ? (a & ((32'h1 << l2(e)) - 1)) + {o, 14'h0} : a;
  endfunction
  task chk(string s, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task note(int k, logic [31:0] v, int dl);
    q.push_back('{cyc + dl, k, v});
  endtask
  task rw(bit w, ptb_addr_t ad, logic [3:0] be, logic [31:0] d, logic [31:0] e);
    ptb_host_model_i.acc(w, ad, be, d);
    if (!w) note(0, e, 1);
  endtask
  always @(negedge clk_i) while (q.size() != 0 && q[0].d <= cyc) begin
    n = q.pop_front();
    case (n.k)
      0: chk("rdata", n.v, reg_rdata_o);
      1: chk("side", n.v, {29'h0, cfg_ro_wr_ok_o, retry_o, io_dec_en_o});
      2: chk("xlat", n.v, xlat_addr_o);
      default: chk("decode", n.v, {2'h0, mem_dec_en_o, bar1_zero_o, mbar_en_o, mbar_win_o, mbar_log2_o});
    endcase
  end
  task tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(74));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1;
    c = 32'h1100;
    note(3, dec(c), 2);
    rw(0, 12'h05C, 4'hF, 0, c);
    for (int i = 0; i < 20; i++) begin
      r = $urandom;
      a = $urandom;
      // all sixteen encodings first, then random byte lanes
      if (i < 16) begin
        a[15:0] = {4{i[3:0]}};
        r[3:0] = 4'hF;
      end
      rw(1, 12'h05C, r[3:0], a, 0);
      for (int b = 0; b < 4; b++) if (r[b]) c[8*b+:8] = a[8*b+:8];
      c &= 32'h000F_FFFF;
      note(3, dec(c), 2);
      rw(1, 12'h060, 4'hF, ~a, 0);
      rw(0, 12'h060, 4'hF, 0, 0);
      rw(0, 12'h05C, 4'hF, 0, c);
      repeat (8) begin
        @(posedge clk_i);
        r = $urandom;
        a = $urandom;
        {cfg_ro_wr_i, retry_req_i, first_phase_i, cmd_io_en_i, xlat_bar_i} <= r[5:0];
        xlat_addr_i <= a;
        xlat_ofs_i <= r[31:14];
        note(1, {c[19] & r[5], r[4] & !(c[18] & !r[3]), c[17] & r[2]}, 2);
        note(2, xl(c[4*r[1:0]+:4], a, r[31:14]), 2);
      end
    end
    repeat (3) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
